// ===== common/ccl_pkg.sv
/*
 configuration control lock register package: offsets, field positions, reset values, carrier types.
 assumes an apb slave with 32-bit data and word-aligned registers.
*/
package ccl_pkg;
  localparam logic [11:0] CFG_CTRL_OFS = 12'h000;
  localparam logic [11:0] PIN_ROUTE_OFS = 12'h010;
  localparam logic [11:0] MOD_GATE_OFS = 12'h020;
  localparam int PIN_LOCK_POS = 13;
  localparam int MOD_LOCK_POS = 12;
  localparam int DBG_EN_POS = 3;
  localparam int TWO_WIRE_POS = 0;
  localparam logic [31:0] CFG_ONES_MASK = 32'h0000_0006;
  localparam logic DBG_EN_RST = 1'b1;
  localparam logic TWO_WIRE_RST = 1'b1;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [31:0] GATED_RST = 32'h0000_0000;

  typedef struct packed {
    logic pin_routing_lock;
    logic module_disable_lock;
    logic debug_port_enable;
    logic two_wire_data_out_use;
  } ccl_cfg_t;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ccl_apb_req_t;
endpackage

// ===== hw/ccl_gated_reg.sv
/*
 one 32-bit software register whose writes can be locked out.
 assumes write strobe and data from the apb slave in the same clock domain.
*/
`timescale 1ns/1ps
module ccl_gated_reg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_stb,
  input wire logic locked,
  input wire logic [31:0] wdata,
  output logic [31:0] value
);
  typedef struct packed {
    logic [31:0] val;
  } ccl_gst_t;

  ccl_gst_t st_q;
  ccl_gst_t st_d;

  always_comb begin
    st_d = st_q;
    // write blocked when locked
    if (wr_stb && !locked) begin
      st_d.val = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{val: ccl_pkg::GATED_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.val;
endmodule

// ===== hw/ccl_top.sv
/*
 configuration control register with pin-routing and module-disable write locks, on apb.
 assumes unlock_active comes from same-clock system logic; gated banks held here as one word each.
*/
// Notes on behaviour
// - pin-routing lock set blocks routing writes
// - module lock set blocks power-gate writes
// - debug enable drives port, resets to one
// - bit zero selects two-wire data-out use
// - lock bits change only after unlock
// - unused bits read zero, bits 2-1 one
`timescale 1ns/1ps
module ccl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic unlock_active,
  output logic debug_port_enable,
  output logic two_wire_data_out_use,
  output logic [31:0] pin_routing_registers,
  output logic [31:0] module_power_gate_registers
);
  typedef struct packed {
    ccl_pkg::ccl_cfg_t cfg;
    logic [31:0] rdata;
    logic err;
  } ccl_st_t;

  ccl_st_t st_q;
  ccl_st_t st_d;
  ccl_pkg::ccl_apb_req_t req;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] cfg_word;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
  assign wr_acc = req.sel && req.en && req.wr;
  assign rd_acc = req.sel && !req.en && !req.wr;

  always_comb begin
    cfg_word = ccl_pkg::CFG_ONES_MASK;
    cfg_word[ccl_pkg::PIN_LOCK_POS] = st_q.cfg.pin_routing_lock;
    cfg_word[ccl_pkg::MOD_LOCK_POS] = st_q.cfg.module_disable_lock;
    cfg_word[ccl_pkg::DBG_EN_POS] = st_q.cfg.debug_port_enable;
    cfg_word[ccl_pkg::TWO_WIRE_POS] = st_q.cfg.two_wire_data_out_use;
  end

  always_comb begin
    st_d = st_q;
    if (wr_acc && hit(req.addr, ccl_pkg::CFG_CTRL_OFS)) begin
      if (unlock_active && pstrb[1]) begin
        st_d.cfg.pin_routing_lock = req.wdata[ccl_pkg::PIN_LOCK_POS];
        st_d.cfg.module_disable_lock = req.wdata[ccl_pkg::MOD_LOCK_POS];
      end
      if (pstrb[0]) begin
        st_d.cfg.debug_port_enable = req.wdata[ccl_pkg::DBG_EN_POS];
        st_d.cfg.two_wire_data_out_use = req.wdata[ccl_pkg::TWO_WIRE_POS];
      end
    end
    if (rd_acc) begin
      st_d.err = 1'b0;
      if (hit(req.addr, ccl_pkg::CFG_CTRL_OFS)) begin
        st_d.rdata = cfg_word;
      end else if (hit(req.addr, ccl_pkg::PIN_ROUTE_OFS)) begin
        st_d.rdata = pin_routing_registers;
      end else if (hit(req.addr, ccl_pkg::MOD_GATE_OFS)) begin
        st_d.rdata = module_power_gate_registers;
      end else begin
        st_d.rdata = 32'h0000_0000;
        st_d.err = 1'b1;
      end
    end else if (req.sel && !req.en) begin
      st_d.rdata = 32'h0000_0000;
      st_d.err = !(hit(req.addr, ccl_pkg::CFG_CTRL_OFS) || hit(req.addr, ccl_pkg::PIN_ROUTE_OFS)
                   || hit(req.addr, ccl_pkg::MOD_GATE_OFS));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{cfg: '{pin_routing_lock: ccl_pkg::LOCK_RST, module_disable_lock: ccl_pkg::LOCK_RST,
                       debug_port_enable: ccl_pkg::DBG_EN_RST, two_wire_data_out_use: ccl_pkg::TWO_WIRE_RST},
                rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ccl_gated_reg u_pin_route (
    .pclk(pclk),
    .presetn(presetn),
    .wr_stb(wr_acc && hit(req.addr, ccl_pkg::PIN_ROUTE_OFS)),
    .locked(st_q.cfg.pin_routing_lock),
    .wdata(req.wdata),
    .value(pin_routing_registers)
  );

  ccl_gated_reg u_mod_gate (
    .pclk(pclk),
    .presetn(presetn),
    .wr_stb(wr_acc && hit(req.addr, ccl_pkg::MOD_GATE_OFS)),
    .locked(st_q.cfg.module_disable_lock),
    .wdata(req.wdata),
    .value(module_power_gate_registers)
  );

  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = st_q.err && psel && penable;
  assign debug_port_enable = st_q.cfg.debug_port_enable;
  assign two_wire_data_out_use = st_q.cfg.two_wire_data_out_use;
endmodule

// ===== tb/ccl_top_checker.sv
/* ccl_top port checker.
 assumes bind to ccl_top, zero-wait apb */
`timescale 1ns/1ps
module ccl_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_port_enable,
  input wire logic two_wire_data_out_use,
  input wire logic [31:0] pin_routing_registers,
  input wire logic [31:0] module_power_gate_registers
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  sequence cfg_wr;
    acc && pwrite && paddr == ccl_pkg::CFG_CTRL_OFS && pstrb[0];
  endsequence
  sequence cfg_rd;
    acc && !pwrite && paddr == ccl_pkg::CFG_CTRL_OFS;
  endsequence
  AST_ROUTE_HOLD: assert property ($changed(pin_routing_registers) |-> $past(acc && pwrite && paddr == ccl_pkg::PIN_ROUTE_OFS))
    else $error("route bank changed without write");
  AST_GATE_HOLD: assert property ($changed(module_power_gate_registers) |-> $past(acc && pwrite && paddr == ccl_pkg::MOD_GATE_OFS))
    else $error("gate bank changed without write");
  AST_DBG_WR: assert property (cfg_wr |=> debug_port_enable == $past(pwdata[3]))
    else $error("debug enable not written");
  AST_TDO_WR: assert property (cfg_wr |=> two_wire_data_out_use == $past(pwdata[0]))
    else $error("data-out use not written");
  AST_CFG_FIXED: assert property (cfg_rd |-> prdata[31:14] == 18'h0 && prdata[11:4] == 8'h0 && prdata[2:1] == 2'h3)
    else $error("fixed bits wrong");
  AST_CFG_MIRROR: assert property (cfg_rd |-> prdata[3] == debug_port_enable && prdata[0] == two_wire_data_out_use)
    else $error("read value differs from outputs");
  AST_READY: assert property (acc |-> pready && (pslverr == !(paddr == ccl_pkg::CFG_CTRL_OFS
    || paddr == ccl_pkg::PIN_ROUTE_OFS || paddr == ccl_pkg::MOD_GATE_OFS)))
    else $error("ready or error wrong");
endmodule
bind ccl_top ccl_top_checker u_chk (.*);

// ===== tb/ccl_top_tb.sv
/* ccl_top self-checking bench.
 assumes zero-wait apb, unlock level at write edge */
`timescale 1ns/1ps
module ccl_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, unlock_active = 0, pready, pslverr, dbg, tw, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, route, gate;
  logic [3:0] pstrb = 4'hF;
  int bad_count = 0, cmp_count = 0;
  always #4 pclk = ~pclk;
  ccl_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .unlock_active, .debug_port_enable(dbg), .two_wire_data_out_use(tw), .pin_routing_registers(route),
    .module_power_gate_registers(gate));
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic t_bits;
    xfer(0, 12'h000, 0); chk("cfg", 32'h0000_000F, rd);
    xfer(1, 12'h000, 32'hFFFF_FFF6); xfer(0, 12'h000, 0); chk("cfg", 32'h0000_0006, rd);
    chk("tdo", 32'h0, tw);
    xfer(1, 12'h000, 32'h0000_0009); chk("dbg", 32'h1, dbg);
  endtask
  task automatic t_lock;
    xfer(1, 12'h010, 32'h0000_00A5); unlock_active <= 1; xfer(1, 12'h000, 32'h0000_3009); unlock_active <= 0;
    xfer(1, 12'h010, 32'h0000_005A); xfer(1, 12'h020, 32'h0000_0077);
    chk("route", 32'h0000_00A5, route);
    chk("gate", 32'h0, gate);
    xfer(1, 12'h000, 32'h0000_0009); xfer(0, 12'h000, 0); chk("cfg", 32'h0000_300F, rd);
    unlock_active <= 1; xfer(1, 12'h000, 32'h0000_0009); unlock_active <= 0;
    xfer(1, 12'h010, 32'h0000_005A); chk("route", 32'h0000_005A, route);
    xfer(1, 12'h020, 32'h0000_0077); chk("gate", 32'h0000_0077, gate);
    xfer(0, 12'h040, 0); chk("err", 32'h1, er); chk("bad", 32'h0, rd);
    xfer(1, 12'h040, 32'h0000_0001); chk("werr", 32'h1, er);
  endtask
  task automatic t_strb;
    unlock_active <= 1; pstrb <= 4'h1; xfer(1, 12'h000, 32'h0000_3000);
    xfer(0, 12'h000, 0); chk("cfg", 32'h0000_0006, rd);
    pstrb <= 4'h2; xfer(1, 12'h000, 32'h0000_3009);
    xfer(0, 12'h000, 0); chk("cfg", 32'h0000_3006, rd);
    pstrb <= 4'hF; xfer(1, 12'h000, 32'h0000_0000); unlock_active <= 0;
    xfer(0, 12'h000, 0); chk("cfg", 32'h0000_0006, rd);
  endtask
  task automatic t_reset;
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 12'h000, 0); chk("cfg", 32'h0000_000F, rd);
    chk("route", 32'h0, route);
    chk("gate", 32'h0, gate);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_bits;
    t_lock;
    t_strb;
    t_reset;
    test_done;
  end
  initial begin
    repeat (2000) @(posedge pclk);
    bad_count++;
    test_done;
  end
endmodule
